// *** verilog/gpm_defines.vh ***
// constants for the general purpose input/output mapper
// assumes inclusion by bare name from the design file
`ifndef GPM_DEFINES_VH
`define GPM_DEFINES_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define GPM_OFS_CTRL 12'h000
`define GPM_OFS_STATUS 12'h004
`define GPM_OFS_IN_BASE 12'h040
`define GPM_OFS_OUT_BASE 12'h080

// ----------------------------------------
// line counts
// ----------------------------------------
`define GPM_NUM_IN 16
`define GPM_NUM_OUT 12
`define GPM_NUM_TRK 8

// ----------------------------------------
// control fields
// ----------------------------------------
`define GPM_CTRL_LEVEL_BIT 0
`define GPM_CTRL_PUNCH_LO 1
`define GPM_CTRL_PUNCH_HI 2
`define GPM_CTRL_RESET 32'h0000_0001

// ----------------------------------------
// punch-in options
// ----------------------------------------
`define GPM_PUNCH_DUAL 2'h0
`define GPM_PUNCH_SINGLE 2'h1
`define GPM_PUNCH_TRACK 2'h2

// ----------------------------------------
// polarity codes, bits [1:0] of a line register
// ----------------------------------------
`define GPM_POL_OFF 2'h0
`define GPM_POL_HIGH 2'h1
`define GPM_POL_LOW 2'h2

// ----------------------------------------
// input functions, bits [12:8] of an input register; track in [18:16]
// ----------------------------------------
`define GPM_FN_NONE 5'h00
`define GPM_FN_PLAY 5'h01
`define GPM_FN_STOP 5'h02
`define GPM_FN_FFWD 5'h03
`define GPM_FN_REW 5'h04
`define GPM_FN_REC 5'h05
`define GPM_FN_PLAY_UNTIL 5'h06
`define GPM_FN_PLAY_OVER 5'h07
`define GPM_FN_PLAY_FROM 5'h08
`define GPM_FN_PLAY_RANGE 5'h09
`define GPM_FN_PLAY_LAST 5'h0a
`define GPM_FN_PLAY_BACK 5'h0b
`define GPM_FN_MARK_IN 5'h0c
`define GPM_FN_MARK_SYNC 5'h0d
`define GPM_FN_MARK_OUT 5'h0e
`define GPM_FN_BIPH_RST 5'h0f
`define GPM_FN_EXT_SWITCH 5'h10
`define GPM_FN_REHEARSE 5'h11
`define GPM_FN_TRK_REC 5'h12
`define GPM_FN_TRK_REC_ON 5'h13
`define GPM_FN_TRK_REC_OFF 5'h14
`define GPM_FN_TRK_PLAY 5'h15
`define GPM_FN_EDIT_TRK 5'h16
`define GPM_FN_SLIP_FP 5'h17
`define GPM_FN_SLIP_FM 5'h18
`define GPM_FN_SLIP_SP 5'h19
`define GPM_FN_SLIP_SM 5'h1a
`define GPM_FN_ALL_PLAY 5'h1b
`define GPM_FN_ALL_READY 5'h1c
`define GPM_FN_ALL_OFF 5'h1d

// ----------------------------------------
// output functions, bits [11:8] of an output register; track in [18:16]
// ----------------------------------------
`define GPM_OF_PLAYING 4'h0
`define GPM_OF_STOPPED 4'h1
`define GPM_OF_LOCATING 4'h2
`define GPM_OF_RECORDING 4'h3
`define GPM_OF_TC_OK 4'h4
`define GPM_OF_WC_OK 4'h5
`define GPM_OF_EXT_LOCKED 4'h6
`define GPM_OF_TRK_REC 4'h7
`define GPM_OF_REHEARSE 4'h8
`define GPM_OF_SLIP 4'h9
`define GPM_OF_MODE 4'ha

`endif

// *** verilog/gpm_mapper.v ***
// general purpose input/output mapper with an ahb-lite register slave
// assumes inputs synchronous to hclk and a transport core alongside
//
// Overview of operation
// [RULE1] sixteen input lines, twelve output lines
// [RULE2] transport inputs give one pulse each
// [RULE3] toggle mode: each pulse inverts track
// [RULE4] toggle mode: record track selects recording
// [RULE5] toggle mode: stopping clears record tracks
// [RULE6] level mode: track follows held input
// [RULE7] output twelve shows mode, drives relay
// [RULE8] punch setting only used in level mode
// [RULE9] dual punch: record and play together
// [RULE10] single punch: record alone starts recording
// [RULE11] track punch: level tracks, motion only
// [RULE12] default input map at reset
// [RULE13] default output map at reset
// [RULE14] input polarity off, high or low
// [RULE15] input transport and marker commands
// [RULE16] track commands and edit slip commands
// [RULE17] output polarity off, high or low
// [RULE18] output transport and sync tallies
// [RULE19] inputs registered, edges become events
// [RULE20] outputs come from registered state
//
// Added by the designer: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "gpm_defines.vh"

module gpm_mapper (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // external lines
    input wire [15:0] gpi_line_in,
    output reg [11:0] gpo_line_out,
    output reg [11:0] gpo_line_oe,
    output reg mode_relay,
    // transport state in
    input wire st_moving,
    input wire st_playing,
    input wire st_stopped,
    input wire st_locating,
    input wire st_recording,
    input wire st_tc_ok,
    input wire st_wc_ok,
    input wire st_ext_locked,
    input wire st_rehearse,
    input wire [7:0] st_slip,
    // command pulses and track levels out
    output reg [17:0] cmd_pulse,
    output reg [7:0] rec_track,
    output reg [7:0] play_toggle,
    output reg [7:0] edit_track,
    output reg [3:0] slip_pulse
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [31:0] ctrl_r;
    reg [18:0] in_cfg_r [0:15];
    reg [18:0] out_cfg_r [0:11];
    reg [15:0] in_sync_r;
    reg [15:0] in_prev_r;
    reg [7:0] rec_trk_r;
    reg moving_d_r;
    reg wr_pend_r;
    reg [11:0] wr_addr_r;

    wire level_mode = ctrl_r[`GPM_CTRL_LEVEL_BIT];
    wire [1:0] punch = ctrl_r[`GPM_CTRL_PUNCH_HI:`GPM_CTRL_PUNCH_LO];

    // polarity decode for the input lines; outputs decode their polarity inline
    function pol_apply;
        input [1:0] pol;
        input v;
        begin
            case (pol)
                `GPM_POL_HIGH: pol_apply = v;
                `GPM_POL_LOW: pol_apply = ~v;
                default: pol_apply = 1'b0;
            endcase
        end
    endfunction

    // ----------------------------------------
    // input conditioning
    // ----------------------------------------
    wire [15:0] act;
    wire [15:0] rise;
    genvar gi;
    generate
        for (gi = 0; gi < `GPM_NUM_IN; gi = gi + 1) begin : g_in
            assign act[gi] = pol_apply(in_cfg_r[gi][1:0], in_sync_r[gi]); // [RULE14]
            assign rise[gi] = act[gi] & ~in_prev_r[gi]; // [RULE19]
        end
    endgenerate

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    reg [17:0] cmd_nxt;
    reg [7:0] trk_tog, trk_on, trk_off, trk_lvl, ptog_nxt, edit_nxt;
    reg [3:0] slip_nxt;
    reg rec_held, play_held, rec_rise, play_rise, any_lvl_map;
    reg [4:0] fn;
    reg [2:0] tk;
    integer i;
    always @* begin
        cmd_nxt = 18'h0;
        trk_tog = 8'h0;
        trk_on = 8'h0;
        trk_off = 8'h0;
        trk_lvl = 8'h0;
        ptog_nxt = 8'h0;
        edit_nxt = 8'h0;
        slip_nxt = 4'h0;
        rec_held = 1'b0;
        play_held = 1'b0;
        rec_rise = 1'b0;
        play_rise = 1'b0;
        any_lvl_map = 1'b0;
        fn = 5'h0;
        tk = 3'h0;
        for (i = 0; i < `GPM_NUM_IN; i = i + 1) begin
            fn = in_cfg_r[i][12:8];
            tk = in_cfg_r[i][18:16];
            // momentary commands map to pulse bits 0..16 by function code
            if (fn >= `GPM_FN_PLAY && fn <= `GPM_FN_REHEARSE && fn != `GPM_FN_REC) begin
                cmd_nxt[fn - 5'h1] = cmd_nxt[fn - 5'h1] | rise[i]; // [RULE2] [RULE15]
            end
            if (fn == `GPM_FN_REC) begin
                rec_held = rec_held | act[i];
                rec_rise = rec_rise | rise[i];
            end
            if (fn == `GPM_FN_PLAY) begin
                play_held = play_held | act[i];
                play_rise = play_rise | rise[i];
            end
            if (fn == `GPM_FN_TRK_REC) begin
                trk_tog[tk] = trk_tog[tk] | rise[i]; // [RULE16]
                trk_lvl[tk] = trk_lvl[tk] | act[i];
                any_lvl_map = any_lvl_map | (in_cfg_r[i][1:0] != `GPM_POL_OFF);
            end
            if (fn == `GPM_FN_TRK_REC_ON) trk_on[tk] = trk_on[tk] | rise[i];
            if (fn == `GPM_FN_TRK_REC_OFF) trk_off[tk] = trk_off[tk] | rise[i];
            if (fn == `GPM_FN_TRK_PLAY) ptog_nxt[tk] = ptog_nxt[tk] | rise[i];
            if (fn == `GPM_FN_EDIT_TRK) edit_nxt[tk] = edit_nxt[tk] | act[i];
            if (fn == `GPM_FN_SLIP_FP) slip_nxt[0] = slip_nxt[0] | rise[i];
            if (fn == `GPM_FN_SLIP_FM) slip_nxt[1] = slip_nxt[1] | rise[i];
            if (fn == `GPM_FN_SLIP_SP) slip_nxt[2] = slip_nxt[2] | rise[i];
            if (fn == `GPM_FN_SLIP_SM) slip_nxt[3] = slip_nxt[3] | rise[i];
            if (fn == `GPM_FN_ALL_PLAY) ptog_nxt = ptog_nxt | {8{rise[i]}};
            if (fn == `GPM_FN_ALL_READY) trk_on = trk_on | {8{rise[i]}};
            if (fn == `GPM_FN_ALL_OFF) trk_off = trk_off | {8{rise[i]}};
        end
        // punch-in rule for the record command; bit 4 is record
        if (!level_mode) begin
            cmd_nxt[4] = rec_rise; // [RULE8]
        end else begin
            case (punch)
                `GPM_PUNCH_DUAL: cmd_nxt[4] = (rec_rise | play_rise) & rec_held & play_held; // [RULE9]
                `GPM_PUNCH_SINGLE: cmd_nxt[4] = rec_rise; // [RULE10]
                default: cmd_nxt[4] = 1'b0;
            endcase
        end
        // bit 17: recording requested by track selection
        cmd_nxt[17] = 1'b0;
    end

    // ----------------------------------------
    // record track state
    // ----------------------------------------
    wire stop_edge = moving_d_r & ~st_moving;
    wire trk_punch = level_mode & (punch == `GPM_PUNCH_TRACK);
    reg [7:0] rec_trk_nxt;
    always @* begin
        rec_trk_nxt = rec_trk_r;
        if (!level_mode) begin
            rec_trk_nxt = rec_trk_r ^ trk_tog; // [RULE3]
        end else if (trk_punch) begin
            // level selection, accepted only in motion // [RULE11]
            rec_trk_nxt = st_moving ? trk_lvl : 8'h0;
        end else if (any_lvl_map) begin
            rec_trk_nxt = trk_lvl; // [RULE6]
        end
        rec_trk_nxt = (rec_trk_nxt | trk_on) & ~trk_off;
        if (trk_punch && !st_moving) rec_trk_nxt = 8'h0;
        if ((!level_mode || trk_punch) && stop_edge) rec_trk_nxt = 8'h0; // [RULE5] [RULE11]
    end
    wire new_sel = |(rec_trk_nxt & ~rec_trk_r);
    wire trk_rec_go = new_sel & (~level_mode | trk_punch); // [RULE4]

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    reg [11:0] gpo_nxt, oe_nxt;
    reg ostate;
    integer k;
    always @* begin
        gpo_nxt = 12'h0;
        oe_nxt = 12'h0;
        ostate = 1'b0;
        for (k = 0; k < `GPM_NUM_OUT; k = k + 1) begin
            case (out_cfg_r[k][11:8]) // [RULE18]
                `GPM_OF_PLAYING: ostate = st_playing;
                `GPM_OF_STOPPED: ostate = st_stopped;
                `GPM_OF_LOCATING: ostate = st_locating;
                `GPM_OF_RECORDING: ostate = st_recording;
                `GPM_OF_TC_OK: ostate = st_tc_ok;
                `GPM_OF_WC_OK: ostate = st_wc_ok;
                `GPM_OF_EXT_LOCKED: ostate = st_ext_locked;
                `GPM_OF_TRK_REC: ostate = rec_trk_r[out_cfg_r[k][18:16]];
                `GPM_OF_REHEARSE: ostate = st_rehearse;
                `GPM_OF_SLIP: ostate = st_slip[out_cfg_r[k][18:16]];
                `GPM_OF_MODE: ostate = level_mode; // [RULE7]
                default: ostate = 1'b0;
            endcase
            // high rests low and drives high when active; low pulls to 0v when active
            gpo_nxt[k] = (out_cfg_r[k][1:0] == `GPM_POL_HIGH) & ostate; // [RULE17]
            oe_nxt[k] = (out_cfg_r[k][1:0] == `GPM_POL_HIGH) |
                        ((out_cfg_r[k][1:0] == `GPM_POL_LOW) & ostate);
        end
    end

    // ----------------------------------------
    // bus slave, zero wait states
    // ----------------------------------------
    wire take = hsel & hready & htrans[1];
    wire [3:0] idx_in = haddr[5:2];
    reg [31:0] rd_nxt;
    always @* begin
        rd_nxt = 32'h0;
        if (haddr == `GPM_OFS_CTRL) rd_nxt = ctrl_r;
        else if (haddr == `GPM_OFS_STATUS) rd_nxt = {8'h0, st_slip, rec_trk_r, in_sync_r[7:0]};
        else if (haddr[11:6] == `GPM_OFS_IN_BASE >> 6) rd_nxt = {13'h0, in_cfg_r[idx_in]};
        else if (haddr[11:6] == `GPM_OFS_OUT_BASE >> 6 && idx_in < 4'hc)
            rd_nxt = {13'h0, out_cfg_r[idx_in]};
    end

    integer j;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= `GPM_CTRL_RESET;
            for (j = 0; j < 8; j = j + 1) begin
                in_cfg_r[j] <= {j[2:0], 3'h0, `GPM_FN_TRK_REC, 6'h0, `GPM_POL_LOW}; // [RULE12]
                out_cfg_r[j] <= {j[2:0], 4'h0, `GPM_OF_TRK_REC, 6'h0, `GPM_POL_LOW}; // [RULE13]
            end
            in_cfg_r[8] <= {6'h0, `GPM_FN_PLAY, 6'h0, `GPM_POL_LOW};
            in_cfg_r[9] <= {6'h0, `GPM_FN_REC, 6'h0, `GPM_POL_LOW};
            in_cfg_r[10] <= {6'h0, `GPM_FN_STOP, 6'h0, `GPM_POL_LOW};
            in_cfg_r[11] <= {6'h0, `GPM_FN_REHEARSE, 6'h0, `GPM_POL_LOW};
            in_cfg_r[12] <= {6'h0, `GPM_FN_NONE, 6'h0, `GPM_POL_OFF};
            in_cfg_r[13] <= {6'h0, `GPM_FN_ALL_PLAY, 6'h0, `GPM_POL_LOW};
            in_cfg_r[14] <= {6'h0, `GPM_FN_ALL_READY, 6'h0, `GPM_POL_LOW};
            in_cfg_r[15] <= {6'h0, `GPM_FN_ALL_OFF, 6'h0, `GPM_POL_LOW};
            out_cfg_r[8] <= {7'h0, `GPM_OF_RECORDING, 6'h0, `GPM_POL_LOW};
            out_cfg_r[9] <= {7'h0, `GPM_OF_PLAYING, 6'h0, `GPM_POL_LOW};
            out_cfg_r[10] <= {7'h0, `GPM_OF_REHEARSE, 6'h0, `GPM_POL_LOW};
            out_cfg_r[11] <= {7'h0, `GPM_OF_MODE, 6'h0, `GPM_POL_LOW};
            in_sync_r <= 16'hffff; // idle lines rest high, so no false edge [RULE19]
            in_prev_r <= 16'h0;
            rec_trk_r <= 8'h0;
            moving_d_r <= 1'b0;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h0;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            gpo_line_out <= 12'h0;
            gpo_line_oe <= 12'h0;
            mode_relay <= 1'b0;
            cmd_pulse <= 18'h0;
            rec_track <= 8'h0;
            play_toggle <= 8'h0;
            edit_track <= 8'h0;
            slip_pulse <= 4'h0;
        end else begin
            // register write lands in the data phase
            wr_pend_r <= take & hwrite;
            wr_addr_r <= haddr;
            if (wr_pend_r) begin
                if (wr_addr_r == `GPM_OFS_CTRL) ctrl_r <= {29'h0, hwdata[2:0]};
                else if (wr_addr_r[11:6] == `GPM_OFS_IN_BASE >> 6)
                    in_cfg_r[wr_addr_r[5:2]] <= {hwdata[18:16], 3'h0, hwdata[12:8], 6'h0, hwdata[1:0]};
                else if (wr_addr_r[11:6] == `GPM_OFS_OUT_BASE >> 6 && wr_addr_r[5:2] < 4'hc)
                    out_cfg_r[wr_addr_r[5:2]] <= {hwdata[18:16], 4'h0, hwdata[11:8], 6'h0, hwdata[1:0]};
            end
            if (take && !hwrite) hrdata <= rd_nxt;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            in_sync_r <= gpi_line_in; // [RULE19]
            in_prev_r <= act;
            moving_d_r <= st_moving;
            rec_trk_r <= rec_trk_nxt;
            gpo_line_out <= gpo_nxt; // [RULE20] [RULE1]
            gpo_line_oe <= oe_nxt;
            mode_relay <= level_mode; // [RULE7]
            cmd_pulse <= {trk_rec_go, cmd_nxt[16:0]};
            rec_track <= rec_trk_nxt;
            play_toggle <= ptog_nxt;
            edit_track <= edit_nxt;
            slip_pulse <= slip_nxt;
        end
    end

endmodule // gpm_mapper

// *** sim/gpm_mapper_checker.sv ***
// checker for the gpio mapper top-level ports
// assumes one clock domain and hreadyout fed back as hready
`timescale 1ns/1ps
module gpm_mapper_checker (
    // clock and reset
    input logic hclk,
    input logic hresetn,
    // bus
    input logic hsel,
    input logic [11:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic hready,
    input logic hreadyout,
    input logic hresp,
    // lines and state
    input logic [15:0] gpi_line_in,
    input logic [11:0] gpo_line_out,
    input logic [11:0] gpo_line_oe,
    input logic mode_relay,
    input logic st_moving,
    input logic [17:0] cmd_pulse,
    input logic [7:0] rec_track,
    input logic [3:0] slip_pulse
);
default clocking cb @(posedge hclk); endclocking
default disable iff (!hresetn);
// ----------------------------------------
// ages since the last cause
// ----------------------------------------
logic [3:0] ctrl_age_r;
logic [3:0] act_age_r;
logic [15:0] gpi_prev_r;
wire take = hsel & hready & htrans[1];
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ctrl_age_r <= 4'h0;
        act_age_r <= 4'h0;
        gpi_prev_r <= 16'hffff;
    end else begin
        gpi_prev_r <= gpi_line_in;
        if (take && hwrite && haddr == 12'h000)
            ctrl_age_r <= 4'h0;
        else if (ctrl_age_r != 4'hf)
            ctrl_age_r <= ctrl_age_r + 4'h1;
        // a polarity write can also make a line active
        if (take || gpi_line_in != gpi_prev_r)
            act_age_r <= 4'h0;
        else if (act_age_r != 4'hf)
            act_age_r <= act_age_r + 4'h1;
    end
end
// ----------------------------------------
// assertions
// ----------------------------------------
a_ready_always: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
a_relay_cause: assert property ($changed(mode_relay) |-> ctrl_age_r < 4'h4)
    else $error("relay moved without a control write");
a_pulse_single: assert property (|cmd_pulse |=> (cmd_pulse & $past(cmd_pulse)) == 18'h0)
    else $error("command pulse longer than one cycle");
a_slip_single: assert property (|slip_pulse |=> slip_pulse == 4'h0)
    else $error("slip pulse longer than one cycle");
a_cmd_cause: assert property (|cmd_pulse[16:0] |-> act_age_r < 4'h6)
    else $error("command pulse without a line edge");
a_oe_covers: assert property ((gpo_line_out & ~gpo_line_oe) == 12'h0)
    else $error("output high while not enabled");
a_stop_clears: assert property (!mode_relay && $fell(st_moving) |-> ##[1:4] rec_track == 8'h0)
    else $error("tracks kept after stop in toggle mode");
a_select_rec: assert property (!mode_relay && (rec_track & ~$past(rec_track)) != 8'h0 |->
    (##[0:3] cmd_pulse[17]) or ($past(cmd_pulse[17]) || $past(cmd_pulse[17], 2)))
    else $error("track select without record start");
endmodule // gpm_mapper_checker

// *** sim/gpm_switch_panel.sv ***
// switch and lamp panel wired to the mapper lines
// assumes press is the logical active state of each switch
`timescale 1ns/1ps
module gpm_switch_panel (
    // clock
    input logic hclk,
    // switch side
    input logic [15:0] press,
    input logic [15:0] act_high,
    output logic [15:0] gpi_line,
    // lamp side
    input logic [11:0] gpo_out,
    input logic [11:0] gpo_oe,
    output logic [11:0] lamp
);
initial gpi_line = 16'hffff;
always @(posedge hclk) begin
    gpi_line <= ~(press ^ act_high);
end
// released outputs float up to the pull-up pin
assign lamp = (gpo_oe & gpo_out) | ~gpo_oe;
endmodule // gpm_switch_panel

// *** sim/general_purpose_io_mapper_test.sv ***
// testbench for the gpio mapper with bus master and switch panel
// assumes no wait states; outputs settle within a few cycles
`timescale 1ns/1ps
module general_purpose_io_mapper_test;
logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, mode_relay;
logic st_moving, st_playing, st_stopped, st_locating, st_recording;
logic st_tc_ok, st_wc_ok, st_ext_locked, st_rehearse;
logic [11:0] haddr, gpo_line_out, gpo_line_oe, lamp;
logic [1:0] htrans;
logic [2:0] hsize;
logic [31:0] hwdata, hrdata;
logic [15:0] gpi_line_in, press, act_high;
logic [7:0] st_slip, rec_track, play_toggle, edit_track;
logic [17:0] cmd_pulse;
logic [3:0] slip_pulse;
wire hready = hreadyout;
int error_cnt = 0;
int checked = 0;
int pc [18];
int sc;
int pt;
gpm_mapper DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .gpi_line_in, .gpo_line_out, .gpo_line_oe, .mode_relay,
    .st_moving, .st_playing, .st_stopped, .st_locating, .st_recording, .st_tc_ok, .st_wc_ok,
    .st_ext_locked, .st_rehearse, .st_slip, .cmd_pulse, .rec_track, .play_toggle,
    .edit_track, .slip_pulse);
gpm_switch_panel u_panel (.hclk, .press, .act_high, .gpi_line(gpi_line_in),
    .gpo_out(gpo_line_out), .gpo_oe(gpo_line_oe), .lamp);
always #5 hclk = ~hclk;
// ----------------------------------------
// tasks
// ----------------------------------------
task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
        error_cnt++;
        $display("wrong value %s expected %h seen %h", nm, e, g);
    end
endtask
task bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
endtask
task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
endtask
task rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
endtask
task run(input int n);
    repeat (n) begin
        @(posedge hclk);
        #1;
        for (int b = 0; b < 18; b++) pc[b] += cmd_pulse[b];
        sc += slip_pulse[0];
        pt += play_toggle;
    end
endtask
task hit(input int i, input logic v);
    @(posedge hclk);
    press[i] <= v;
endtask
task mv(input logic v);
    @(posedge hclk);
    st_moving <= v;
    run(5);
endtask
// one press held for four cycles, pulse counts cleared first
task tap(input int i);
    pc = '{default: 0};
    sc = 0;
    pt = 0;
    hit(i, 1'b1);
    run(3);
    hit(i, 1'b0);
    run(4);
endtask
task finish_test;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask
// ----------------------------------------
// main sequence
// ----------------------------------------
initial begin
    {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata, press, act_high} = '0;
    {st_moving, st_playing, st_stopped, st_locating, st_recording} = '0;
    {st_tc_ok, st_wc_ok, st_ext_locked, st_rehearse, st_slip} = '0;
    hsize = 3'h2;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd("ctrl", 12'h000, 32'h1);
    chk("relay", 32'h1, mode_relay);
    chk("mode tally", 32'h1, gpo_line_oe[11]);
    rd("play input map", 12'h060, 32'h102);
    rd("spare input map", 12'h070, 32'h0);
    rd("unmapped", 12'h0fc, 32'h0);
    st_slip <= 8'ha5;
    wr(12'h004, 32'hffff_ffff);
    rd("status", 12'h004, 32'h00a5_00ff);
    $display("test registers done");
    tap(8);
    chk("play once", 32'h1, pc[0]);
    wr(12'h060, 32'h100);
    tap(8);
    chk("play off", 32'h0, pc[0]);
    @(posedge hclk) act_high[8] <= 1'b1;
    run(2);
    wr(12'h060, 32'h101);
    tap(8);
    chk("play high", 32'h1, pc[0]);
    $display("test input polarity done");
    hit(0, 1'b1);
    run(5);
    chk("track held", 32'h1, rec_track);
    hit(0, 1'b0);
    run(5);
    chk("track freed", 32'h0, rec_track);
    hit(9, 1'b1);
    pc = '{default: 0};
    run(6);
    chk("record alone", 32'h0, pc[4]);
    tap(8);
    chk("record with play", 32'h1, pc[4]);
    hit(9, 1'b0);
    wr(12'h000, 32'h3);
    tap(9);
    chk("single punch", 32'h1, pc[4]);
    wr(12'h000, 32'h5);
    tap(9);
    chk("track punch record", 32'h0, pc[4]);
    hit(2, 1'b1);
    run(5);
    chk("track idle", 32'h0, rec_track);
    mv(1'b1);
    chk("track moving", 32'h4, rec_track);
    mv(1'b0);
    chk("track stopped", 32'h0, rec_track);
    hit(2, 1'b0);
    $display("test level mode done");
    wr(12'h000, 32'h4);
    run(3);
    chk("relay toggle", 32'h0, mode_relay);
    chk("mode tally off", 32'h0, gpo_line_oe[11]);
    tap(1);
    chk("select records", 32'h1, pc[17]);
    chk("toggle on", 32'h2, rec_track);
    tap(1);
    chk("toggle off", 32'h0, rec_track);
    tap(1);
    mv(1'b1);
    chk("moving keeps", 32'h2, rec_track);
    mv(1'b0);
    chk("stop clears", 32'h0, rec_track);
    $display("test toggle mode done");
    @(posedge hclk);
    st_playing <= 1'b1;
    st_recording <= 1'b1;
    run(4);
    chk("play tally low", 32'h2, {gpo_line_oe[9], gpo_line_out[9]});
    chk("record tally", 32'h1, gpo_line_oe[8]);
    chk("lamp low", 32'h0, lamp[9]);
    wr(12'h0a4, 32'h1);
    run(3);
    chk("play tally high", 32'h3, {gpo_line_oe[9], gpo_line_out[9]});
    @(posedge hclk) st_playing <= 1'b0;
    run(4);
    chk("play tally rest", 32'h2, {gpo_line_oe[9], gpo_line_out[9]});
    wr(12'h0a4, 32'h0);
    run(3);
    chk("tally disabled", 32'h0, {gpo_line_oe[9], gpo_line_out[9]});
    chk("lamp released", 32'h1, lamp[9]);
    $display("test outputs done");
    tap(13);
    chk("all play", 32'hff, pt);
    wr(12'h070, 32'h0000_1702);
    wr(12'h074, 32'h0004_1602);
    hit(13, 1'b1);
    run(5);
    chk("edit track", 32'h10, edit_track);
    tap(12);
    chk("slip frame", 32'h1, sc);
    hit(13, 1'b0);
    run(3);
    $display("test track commands done");
    finish_test;
end
initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    finish_test;
end
endmodule // general_purpose_io_mapper_test
bind gpm_mapper gpm_mapper_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hreadyout, .hresp, .gpi_line_in, .gpo_line_out, .gpo_line_oe, .mode_relay,
    .st_moving, .cmd_pulse, .rec_track, .slip_pulse);
